/* File: verilog/dcbr_top.sv */
// Purpose: two 16-bit up counters, shared 32-bit store, byte-wide readout
// Assumes: all pins except srst_i sampled into mclk_i through two flops
// Notes:   count and register clocks act on their sampled rising edges
`include "dcbr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module dcbr_top (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // count pins
    input  wire logic        count_clock_a_i,
    input  wire logic        count_clock_b_i,
    input  wire logic        count_b_enable_n_i,
    input  wire logic        shared_clear_n_i,
    input  wire logic        register_clock_i,
    // byte gates
    input  wire logic        gate_a_low_byte_n_i,
    input  wire logic        gate_a_high_byte_n_i,
    input  wire logic        gate_b_low_byte_n_i,
    input  wire logic        gate_b_high_byte_n_i,
    // outputs
    output logic             terminal_count_a_n_o,
    output logic [7:0]       data_o,
    output logic             data_oe_n_o
);
    // ----------------------------------------
    // local sizes
    // ----------------------------------------
    localparam int PIN_N  = 9;
    localparam int EDGE_N = 3;
    localparam int CNT_N  = 2;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // next count: one step up when enabled
    function automatic logic [`DCBR_CNT_W-1:0] dcbr_step(
        input logic [`DCBR_CNT_W-1:0] value,
        input logic                   en
    );
        if (en) begin
            return value + `DCBR_CNT_ONE;
        end else begin
            return value;
        end
    endfunction

    // gate pins to byte code, fixed priority
    function automatic dcbr_pkg::dcbr_sel_t dcbr_pick(
        input logic [3:0] gates_n
    );
        if (!gates_n[3]) begin
            return dcbr_pkg::DCBR_SEL_AL;
        end else if (!gates_n[2]) begin
            return dcbr_pkg::DCBR_SEL_AH;
        end else if (!gates_n[1]) begin
            return dcbr_pkg::DCBR_SEL_BL;
        end else if (!gates_n[0]) begin
            return dcbr_pkg::DCBR_SEL_BH;
        end else begin
            return dcbr_pkg::DCBR_SEL_NONE;
        end
    endfunction

    // stored byte for a code
    function automatic logic [`DCBR_BYTE_W-1:0] dcbr_byte(
        input logic [`DCBR_STORE_W-1:0] word,
        input dcbr_pkg::dcbr_sel_t      code
    );
        unique case (code)
            dcbr_pkg::DCBR_SEL_AL:   return word[7:0];
            dcbr_pkg::DCBR_SEL_AH:   return word[15:8];
            dcbr_pkg::DCBR_SEL_BL:   return word[23:16];
            dcbr_pkg::DCBR_SEL_BH:   return word[31:24];
            dcbr_pkg::DCBR_SEL_NONE: return 8'h00;
            default:                 return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PIN_N-1:0] pins_raw;
    logic [PIN_N-1:0] pins_s;

    assign pins_raw = {count_clock_a_i,
                       count_clock_b_i,
                       count_b_enable_n_i,
                       shared_clear_n_i,
                       register_clock_i,
                       gate_a_low_byte_n_i,
                       gate_a_high_byte_n_i,
                       gate_b_low_byte_n_i,
                       gate_b_high_byte_n_i};

    dcbr_sync #(
        .W (PIN_N)
    ) u_sync (
        .mclk_i  (mclk_i),
        .async_i (pins_raw),
        .sync_o  (pins_s)
    );

    // ----------------------------------------
    // pin views
    // ----------------------------------------
    wire       count_clock_a_s    = pins_s[8];
    wire       count_clock_b_s    = pins_s[7];
    wire       benn_s    = pins_s[6];
    wire       clrn_s    = pins_s[5];
    wire       rclk_s    = pins_s[4];
    wire [3:0] gates_n_s = pins_s[3:0];

    // ----------------------------------------
    // edge detect
    // ----------------------------------------
    // bit 0 count clock a, bit 1 count clock b, bit 2 register clock
    logic [EDGE_N-1:0] edge_in_s;
    logic [EDGE_N-1:0] edge_d_r;
    wire  [EDGE_N-1:0] edge_rise;

    assign edge_in_s = {rclk_s, count_clock_b_s, count_clock_a_s};

    // delay stage follows the pin even in reset, so no false edge after it
    always_ff @(posedge mclk_i) begin
        edge_d_r <= edge_in_s;
    end

    for (genvar e = 0; e < EDGE_N; e++) begin : g_edge
        assign edge_rise[e] = edge_in_s[e] & ~edge_d_r[e];
    end

    // ----------------------------------------
    // counters
    // ----------------------------------------
    // counter a is element 0, counter b element 1
    wire                   clear_now = srst_i | ~clrn_s;
    wire [CNT_N-1:0]       step_en;
    wire [`DCBR_CNT_W-1:0] cnt_q   [CNT_N];
    wire [`DCBR_CNT_W-1:0] cnt_nxt [CNT_N];

    assign step_en[0] = edge_rise[0];
    assign step_en[1] = edge_rise[1] & ~benn_s;

    for (genvar k = 0; k < CNT_N; k++) begin : g_cnt
        logic [`DCBR_CNT_W-1:0] cnt_r;

        assign cnt_nxt[k] = dcbr_step(cnt_r, step_en[k]);
        assign cnt_q[k]   = cnt_r;

        always_ff @(posedge mclk_i) begin
            if (clear_now) begin
                cnt_r <= `DCBR_CNT_ZERO;
            end else begin
                cnt_r <= cnt_nxt[k];
            end
        end
    end

    // ----------------------------------------
    // terminal count
    // ----------------------------------------
    // full next cycle unless a clear wins
    wire a_full_nxt = ~clear_now & (cnt_nxt[0] == `DCBR_CNT_FULL);

    // ----------------------------------------
    // storage register
    // ----------------------------------------
    logic [`DCBR_STORE_W-1:0] store_r;
    wire  [`DCBR_STORE_W-1:0] store_nxt = {cnt_q[1], cnt_q[0]};

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            store_r <= {`DCBR_CNT_ZERO, `DCBR_CNT_ZERO};
        end else if (edge_rise[2]) begin
            store_r <= store_nxt;
        end
    end

    // ----------------------------------------
    // byte select
    // ----------------------------------------
    dcbr_pkg::dcbr_sel_t     sel;
    logic [`DCBR_BYTE_W-1:0] byte_nxt;
    logic                    oe_n_nxt;

    assign sel      = dcbr_pick(gates_n_s);
    assign byte_nxt = dcbr_byte(store_r, sel);
    assign oe_n_nxt = (sel == dcbr_pkg::DCBR_SEL_NONE);

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // byte bus, zero while released
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_o <= 8'h00;
        end else begin
            data_o <= byte_nxt;
        end
    end

    // bus enable, high releases the bus
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_oe_n_o <= 1'b1;
        end else begin
            data_oe_n_o <= oe_n_nxt;
        end
    end

    // terminal count, low while counter a is full
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            terminal_count_a_n_o <= 1'b1;
        end else begin
            terminal_count_a_n_o <= ~a_full_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/dcbr_map.svh */
// Purpose: constants for the dual counter with byte readout
// Assumes: single clock mclk_i at 25 MHz
// Notes:   widths and count constants shared by the design files
`ifndef DCBR_MAP_SVH
`define DCBR_MAP_SVH
`define DCBR_CNT_W     16
`define DCBR_STORE_W   32
`define DCBR_BYTE_W    8
`define DCBR_CNT_ZERO  16'h0000
`define DCBR_CNT_FULL  16'hFFFF
`define DCBR_CNT_ONE   16'h0001
`define DCBR_SYNC_ZERO 2'h0
`endif

/* File: verilog/dcbr_pkg.sv */
// Purpose: types for the dual counter with byte readout
// Assumes: nothing
// Notes:   byte selection codes
package dcbr_pkg;
    typedef enum logic [2:0] {
        DCBR_SEL_NONE,
        DCBR_SEL_AL,
        DCBR_SEL_AH,
        DCBR_SEL_BL,
        DCBR_SEL_BH
    } dcbr_sel_t;
endpackage

/* File: verilog/dcbr_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs come from outside mclk_i
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module dcbr_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         mclk_i,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk_i) begin
        meta_r <= async_i;
        sync_o <= meta_r;
    end
endmodule
`default_nettype wire

/* File: tb/dcbr_checker.sv */
// Purpose: port checks for dcbr_top
// Assumes: one clock mclk_i
// Notes:   bound at the foot
`timescale 1ns/1ns
`default_nettype none
module dcbr_checker (
    // pins
    input wire logic       mclk_i,
    input wire logic       srst_i,
    input wire logic       count_clock_a_i,
    input wire logic       shared_clear_n_i,
    input wire logic       register_clock_i,
    input wire logic       gate_a_low_byte_n_i,
    input wire logic       gate_a_high_byte_n_i,
    input wire logic       gate_b_low_byte_n_i,
    input wire logic       gate_b_high_byte_n_i,
    input wire logic       terminal_count_a_n_o,
    input wire logic [7:0] data_o,
    input wire logic       data_oe_n_o
);
    wire logic [3:0] gates = {gate_b_high_byte_n_i, gate_b_low_byte_n_i, gate_a_high_byte_n_i, gate_a_low_byte_n_i};
    wire logic       idle = &gates;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence s_idle; idle [*5]; endsequence
    sequence s_al_low; (!gate_a_low_byte_n_i) [*5]; endsequence
    a_oe_release: assert property (s_idle |-> data_oe_n_o) else $error("bus driven with no gate");
    a_oe_drive: assert property (s_al_low |-> !data_oe_n_o) else $error("bus not driven");
    a_oe_quick: assert property ($rose(idle) |-> ##[1:4] data_oe_n_o) else $error("bus release late");
    a_data_idle: assert property (data_oe_n_o |-> data_o == 8'h00) else $error("idle data not zero");
    a_data_hold: assert property (($stable(gates) && $stable(register_clock_i)) [*6] |-> $stable(data_o))
        else $error("data changed alone");
    a_tc_hold: assert property (($stable(count_clock_a_i) && shared_clear_n_i) [*6]
        |-> $stable(terminal_count_a_n_o)) else $error("tc changed alone");
    a_clear_tc: assert property ((!shared_clear_n_i) [*6] |-> terminal_count_a_n_o) else $error("tc low in clear");
    a_clear_fast: assert property ($fell(shared_clear_n_i) |-> ##[1:6] terminal_count_a_n_o)
        else $error("clear slow");
endmodule
bind dcbr_top dcbr_checker chk (.mclk_i(mclk_i), .srst_i(srst_i), .count_clock_a_i(count_clock_a_i),
    .shared_clear_n_i(shared_clear_n_i), .register_clock_i(register_clock_i),
    .gate_a_low_byte_n_i(gate_a_low_byte_n_i), .gate_a_high_byte_n_i(gate_a_high_byte_n_i),
    .gate_b_low_byte_n_i(gate_b_low_byte_n_i), .gate_b_high_byte_n_i(gate_b_high_byte_n_i),
    .terminal_count_a_n_o(terminal_count_a_n_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o));
`default_nettype wire

/* File: tb/dcbr_host.sv */
// Purpose: host reading the byte bus
// Assumes: one gate at a time
// Notes:   released bus shows inverse of last value
`timescale 1ns/1ns
`default_nettype none
module dcbr_host (
    // control and bus
    input wire logic       mclk_i,
    input wire logic       en_i,
    input wire logic [1:0] sel_i,
    input wire logic       oe_n_i,
    input wire logic [7:0] data_i,
    output logic     [3:0] gate_n_o,
    output logic     [7:0] bus_o
);
    logic [7:0] last_r;
    assign gate_n_o = en_i ? ~(4'h1 << sel_i) : 4'hF;
    assign bus_o = oe_n_i ? ~last_r : data_i;
    always_ff @(posedge mclk_i) last_r <= bus_o;
endmodule
`default_nettype wire

/* File: tb/dcbr_top_tb.sv */
// Purpose: self-checking bench for dcbr_top
// Assumes: pins held 6 cycles per phase
// Notes:   expected bytes queued, monitor compares
`timescale 1ns/1ns
`default_nettype none
module dcbr_top_tb;
    logic       mclk_i = 0, srst_i = 1, ca = 0, cb = 0, en_n = 1, clr_n = 1, rclk = 0, rd = 0, chain = 0;
    logic [1:0] sel = 0;
    logic [3:0] g;
    logic [7:0] d, bus, q[$];
    logic       tc, oe, oe_q = 1;
    logic [15:0] ea = 0, eb = 0;
    int         bad_count = 0, cmp_count = 0, cyc = 0, seed = 32'h47e2fb77, n;
    initial forever #20 mclk_i = ~mclk_i;
    dcbr_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .count_clock_a_i(ca), .count_clock_b_i(cb),
        .count_b_enable_n_i(chain ? tc : en_n), .shared_clear_n_i(clr_n), .register_clock_i(rclk),
        .gate_a_low_byte_n_i(g[0]), .gate_a_high_byte_n_i(g[1]), .gate_b_low_byte_n_i(g[2]),
        .gate_b_high_byte_n_i(g[3]), .terminal_count_a_n_o(tc), .data_o(d), .data_oe_n_o(oe));
    dcbr_host host (.mclk_i(mclk_i), .en_i(rd), .sel_i(sel), .oe_n_i(oe), .data_i(d), .gate_n_o(g), .bus_o(bus));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic pulse(input logic [2:0] w);
        {ca, cb, rclk} = w;
        wt(6);
        {ca, cb, rclk} = 3'h0;
        wt(6);
    endtask
    task automatic rd4(input logic [31:0] s);
        for (int i = 0; i < 4; i++) begin
            q.push_back(s[8*i +: 8]);
            sel = 2'(i);
            rd = 1;
            wt(6);
            rd = 0;
            wt(6);
            check("oe", {7'h00, oe}, 8'h01);
            check("tc", {7'h00, tc}, 8'h01);
        end
    endtask
    always @(negedge mclk_i) begin
        oe_q <= oe;
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            bad_count++;
            conclude();
        end
        if (oe_q === 1'b1 && oe === 1'b0 && q.size() > 0) check("byte", bus, q.pop_front());
    end
    // ----
    // count, store, read
    // ----
    initial begin
        wt(20);
        srst_i = 0;
        wt(4);
        repeat (3) begin
            n = 1 + ($unsigned($random(seed)) % 12);
            repeat (n) begin
                en_n = 1'($random(seed));
                wt(3);
                pulse(3'h6);
                ea++;
                if (!en_n) eb++;
            end
            pulse(3'h1);
            rd4({eb, ea});
        end
        clr_n = 0;
        wt(6);
        pulse(3'h7);
        clr_n = 1;
        chain = 1;
        pulse(3'h6);
        pulse(3'h6);
        pulse(3'h1);
        rd4({16'h0000, 16'h0002});
        wt(4);
        check("queue", 8'(q.size()), 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
